/* File: hdl/cpfs_pkg.sv */
// Purpose: Shared constants and types for the core register/PC/stack block
// Assumes: 8-bit data space, 12-bit program space
// Notes: Data-space offsets, reset values and command codes live here
package cpfs_pkg;

  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int STACK_LEVELS = 6;
  localparam int DEPTH_W = 3;
  localparam int CORE_DIV_DEFAULT = 1;
  localparam int SD_CORE_CYCLES = 4;

  localparam logic [7:0] ADDR_FIRST_POINTER = 8'h80;
  localparam logic [7:0] ADDR_SECOND_POINTER = 8'h81;
  localparam logic [7:0] ADDR_FIRST_SHORT_DIRECT = 8'h82;
  localparam logic [7:0] ADDR_SECOND_SHORT_DIRECT = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hff;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'hffe;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [2:0] SD_COUNT_RESET = 3'h0;
  localparam logic [2:0] SD_COUNT_LOAD = 3'h4;

  typedef enum logic [3:0] {
    PC_HOLD = 4'h0,
    PC_SEQ = 4'h1,
    PC_BRANCH = 4'h2,
    PC_JUMP = 4'h3,
    PC_CALL = 4'h4,
    PC_IRQ = 4'h5,
    PC_NMI = 4'h6,
    PC_RET = 4'h7,
    PC_INTERRUPT_RETURN = 4'h8
  } cpfs_pc_op_t;

  typedef enum logic [2:0] {
    CTX_MAIN = 3'b001,
    CTX_IRQ = 3'b010,
    CTX_URGENT = 3'b100
  } cpfs_ctx_t;

  typedef struct packed {
    cpfs_pc_op_t op;
    logic [11:0] target;
  } cpfs_pc_cmd_t;

  typedef struct packed {
    logic carry_we;
    logic carry;
    logic zero_we;
    logic zero;
  } cpfs_flag_upd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpfs_ds_req_t;

endpackage

/* File: hdl/cpfs_stack.sv */
// Purpose: Six-level shift-register return stack
// Assumes: push and pop are never both high; step qualifies both
// Notes: No pointer; depth is tracked for empty, for saturation at full and as the depth output
`timescale 1ns/1ps
`default_nettype none
module cpfs_stack
  import cpfs_pkg::*;
#(
  parameter int LEVELS = STACK_LEVELS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic step,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] push_data,
  // State
  output logic [PC_W-1:0] top,
  output logic empty,
  output logic [DEPTH_W-1:0] depth
);

  logic [PC_W-1:0] lvl [LEVELS];
  logic [PC_W-1:0] next_lvl [LEVELS];
  logic [DEPTH_W-1:0] next_depth;

  genvar g;
  generate
    for (g = 0; g < LEVELS; g++)
    begin : g_lvl
      always_comb
      begin
        next_lvl[g] = lvl[g];
        if (step && push)
        begin
          // Deepest level is dropped on overflow
          next_lvl[g] = (g == 0) ? push_data : lvl[(g == 0) ? 0 : g-1];
        end
        else if (step && pop && depth != '0)
        begin
          // Last level keeps its value when levels move upward
          next_lvl[g] = (g == LEVELS-1) ? lvl[g] : lvl[(g == LEVELS-1) ? g : g+1];
        end
      end
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          lvl[g] <= '0;
        else
          lvl[g] <= next_lvl[g];
      end
    end
  endgenerate

  always_comb
  begin
    next_depth = depth;
    if (step && push && depth != DEPTH_W'(LEVELS))
      next_depth = depth + 3'h1;
    else if (step && pop && depth != '0)
      next_depth = depth - 3'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      depth <= '0;
    else
      depth <= next_depth;
  end

  assign top = lvl[0];
  assign empty = (depth == '0);

endmodule
`default_nettype wire

/* File: hdl/cpfs_core_regs.sv */
// Purpose: Accumulator, pointer and short-direct registers, program
//   counter, banked carry/zero pairs and the return stack of the core
// Assumes: sequencer issues one command per core cycle enable
// Notes: All updates of one event commit on the same core_en edge
`timescale 1ns/1ps
`default_nettype none
module cpfs_core_regs
  import cpfs_pkg::*;
#(
  parameter int CORE_DIV = CORE_DIV_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data-space port
  input wire cpfs_ds_req_t ds_req,
  output logic [DATA_W-1:0] ds_rdata,
  output logic ds_ack,
  // ALU results
  input wire logic acc_we,
  input wire logic [DATA_W-1:0] acc_wdata,
  input wire cpfs_flag_upd_t flag_upd,
  // Program counter commands
  input wire cpfs_pc_cmd_t pc_cmd,
  output logic [PC_W-1:0] program_counter,
  // Addressing helpers
  input wire logic ind_sel,
  output logic [DATA_W-1:0] ind_addr,
  input wire logic sd_start,
  input wire logic [1:0] sd_sel,
  output logic [DATA_W-1:0] sd_addr,
  output logic sd_busy,
  // Visible state
  output logic [DATA_W-1:0] accumulator,
  output logic [DATA_W-1:0] first_pointer,
  output logic [DATA_W-1:0] second_pointer,
  output logic [DATA_W-1:0] first_short_direct,
  output logic [DATA_W-1:0] second_short_direct,
  output logic active_carry,
  output logic active_zero,
  output cpfs_ctx_t context_sel,
  output logic [DEPTH_W-1:0] stack_depth
);

  function automatic logic ds_hit(input logic [7:0] a);
    ds_hit = (a == ADDR_ACCUMULATOR) || (a[7:2] == ADDR_FIRST_POINTER[7:2]);
  endfunction

  function automatic logic pick_flag(input cpfs_ctx_t c, input logic m,
                                     input logic i, input logic u);
    case (c)
      CTX_MAIN: pick_flag = m;
      CTX_IRQ: pick_flag = i;
      default: pick_flag = u;
    endcase
  endfunction

  // Core cycle enable divider
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic core_en;

  always_comb
  begin
    core_en = (div_cnt == 16'(CORE_DIV - 1));
    next_div_cnt = core_en ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= 16'h0000;
    else
      div_cnt <= next_div_cnt;
  end

  // Data-space registers
  logic [DATA_W-1:0] next_acc, next_fp, next_sp, next_fsd, next_ssd;
  logic [DATA_W-1:0] next_rdata, next_ind, next_sd_addr;
  logic next_ack;
  logic [2:0] sd_cnt, next_sd_cnt;
  logic ds_wr;

  always_comb
  begin
    ds_wr = core_en && ds_req.wr;
    next_fp = first_pointer;
    next_sp = second_pointer;
    next_fsd = first_short_direct;
    next_ssd = second_short_direct;
    next_acc = accumulator;
    if (ds_wr && ds_req.addr == ADDR_FIRST_POINTER)
      next_fp = ds_req.wdata;
    if (ds_wr && ds_req.addr == ADDR_SECOND_POINTER)
      next_sp = ds_req.wdata;
    if (ds_wr && ds_req.addr == ADDR_FIRST_SHORT_DIRECT)
      next_fsd = ds_req.wdata;
    if (ds_wr && ds_req.addr == ADDR_SECOND_SHORT_DIRECT)
      next_ssd = ds_req.wdata;
    // ALU result wins over a data-space write in the same cycle
    if (core_en && acc_we)
      next_acc = acc_wdata;
    else if (ds_wr && ds_req.addr == ADDR_ACCUMULATOR)
      next_acc = ds_req.wdata;
    next_rdata = ds_rdata;
    next_ack = 1'b0;
    if (core_en && ds_req.rd)
    begin
      next_ack = ds_hit(ds_req.addr);
      case (ds_req.addr)
        ADDR_FIRST_POINTER: next_rdata = first_pointer;
        ADDR_SECOND_POINTER: next_rdata = second_pointer;
        ADDR_FIRST_SHORT_DIRECT: next_rdata = first_short_direct;
        ADDR_SECOND_SHORT_DIRECT: next_rdata = second_short_direct;
        ADDR_ACCUMULATOR: next_rdata = accumulator;
        default: next_rdata = REG_RESET;
      endcase
    end
    next_ind = ind_sel ? next_sp : next_fp;
    // Short-direct slots 0..3 map onto 80h..83h, pointers included
    next_sd_addr = sd_addr;
    next_sd_cnt = sd_cnt;
    if (core_en && sd_cnt != SD_COUNT_RESET)
      next_sd_cnt = sd_cnt - 3'h1;
    else if (core_en && sd_start)
    begin
      next_sd_cnt = SD_COUNT_LOAD;
      next_sd_addr = {ADDR_FIRST_POINTER[7:2], sd_sel};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accumulator <= REG_RESET;
      first_pointer <= REG_RESET;
      second_pointer <= REG_RESET;
      first_short_direct <= REG_RESET;
      second_short_direct <= REG_RESET;
      ds_rdata <= REG_RESET;
      ds_ack <= 1'b0;
      ind_addr <= REG_RESET;
      sd_addr <= REG_RESET;
      sd_cnt <= SD_COUNT_RESET;
      sd_busy <= 1'b0;
    end
    else
    begin
      accumulator <= next_acc;
      first_pointer <= next_fp;
      second_pointer <= next_sp;
      first_short_direct <= next_fsd;
      second_short_direct <= next_ssd;
      ds_rdata <= next_rdata;
      ds_ack <= next_ack;
      ind_addr <= next_ind;
      sd_addr <= next_sd_addr;
      sd_cnt <= next_sd_cnt;
      sd_busy <= (next_sd_cnt != SD_COUNT_RESET);
    end
  end

  // Program counter and stack
  logic [PC_W-1:0] next_pc, stack_top;
  logic push, pop, stack_empty;

  always_comb
  begin
    push = (pc_cmd.op == PC_CALL) || (pc_cmd.op == PC_IRQ) ||
           (pc_cmd.op == PC_NMI);
    pop = (pc_cmd.op == PC_RET) || (pc_cmd.op == PC_INTERRUPT_RETURN);
    next_pc = program_counter;
    if (core_en)
    begin
      case (pc_cmd.op)
        PC_SEQ: next_pc = program_counter + PC_STEP;
        PC_BRANCH: next_pc = pc_cmd.target;
        PC_JUMP, PC_CALL, PC_IRQ, PC_NMI: next_pc = pc_cmd.target;
        PC_RET, PC_INTERRUPT_RETURN:
          next_pc = stack_empty ? program_counter : stack_top;
        default: next_pc = program_counter;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      program_counter <= PC_RESET;
    else
      program_counter <= next_pc;
  end

  cpfs_stack #(
    .LEVELS(STACK_LEVELS)
  ) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .step(core_en),
    .push(push),
    .pop(pop),
    .push_data(program_counter),
    .top(stack_top),
    .empty(stack_empty),
    .depth(stack_depth)
  );

  // Context and banked flags
  cpfs_ctx_t saved_ctx, next_ctx, next_saved;
  logic main_carry, main_zero, irq_carry, irq_zero;
  logic urgent_carry, urgent_zero;
  logic next_mc, next_mz, next_ic, next_iz, next_uc, next_uz;
  logic upd_c, upd_z;

  always_comb
  begin
    next_ctx = context_sel;
    next_saved = saved_ctx;
    if (core_en)
    begin
      case (pc_cmd.op)
        PC_IRQ:
          if (context_sel == CTX_MAIN)
            next_ctx = CTX_IRQ;
        PC_NMI:
        begin
          next_saved = context_sel;
          next_ctx = CTX_URGENT;
        end
        PC_INTERRUPT_RETURN:
          case (context_sel)
            CTX_URGENT:
            begin
              next_ctx = saved_ctx;
              next_saved = CTX_MAIN;
            end
            CTX_IRQ: next_ctx = CTX_MAIN;
            default: next_ctx = CTX_MAIN;
          endcase
        default: next_ctx = context_sel;
      endcase
    end
    // Only the pair of the context current at the event is written
    upd_c = core_en && flag_upd.carry_we;
    upd_z = core_en && flag_upd.zero_we;
    next_mc = (upd_c && context_sel == CTX_MAIN) ? flag_upd.carry : main_carry;
    next_mz = (upd_z && context_sel == CTX_MAIN) ? flag_upd.zero : main_zero;
    next_ic = (upd_c && context_sel == CTX_IRQ) ? flag_upd.carry : irq_carry;
    next_iz = (upd_z && context_sel == CTX_IRQ) ? flag_upd.zero : irq_zero;
    next_uc = (upd_c && context_sel == CTX_URGENT) ? flag_upd.carry
                                                   : urgent_carry;
    next_uz = (upd_z && context_sel == CTX_URGENT) ? flag_upd.zero
                                                   : urgent_zero;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      context_sel <= CTX_URGENT;
      saved_ctx <= CTX_MAIN;
      main_carry <= 1'b0;
      main_zero <= 1'b0;
      irq_carry <= 1'b0;
      irq_zero <= 1'b0;
      urgent_carry <= 1'b0;
      urgent_zero <= 1'b0;
      active_carry <= 1'b0;
      active_zero <= 1'b0;
    end
    else
    begin
      context_sel <= next_ctx;
      saved_ctx <= next_saved;
      main_carry <= next_mc;
      main_zero <= next_mz;
      irq_carry <= next_ic;
      irq_zero <= next_iz;
      urgent_carry <= next_uc;
      urgent_zero <= next_uz;
      active_carry <= pick_flag(next_ctx, next_mc, next_ic, next_uc);
      active_zero <= pick_flag(next_ctx, next_mz, next_iz, next_uz);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_seq_step;
    core_en && pc_cmd.op == PC_SEQ |=>
      program_counter == $past(program_counter) + PC_STEP;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("counter did not step by one");

  property p_jump_load;
    core_en && (pc_cmd.op == PC_JUMP || pc_cmd.op == PC_BRANCH) |=>
      program_counter == $past(pc_cmd.target);
  endproperty
  a_jump_load: assert property (p_jump_load)
    else $error("counter not loaded with target");

  property p_call_push;
    core_en && pc_cmd.op == PC_CALL |=>
      stack_top == $past(program_counter) && !stack_empty;
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call did not push counter");

  property p_ret_pop;
    core_en && pc_cmd.op == PC_RET && !stack_empty |=>
      program_counter == $past(stack_top) &&
      stack_depth == $past(stack_depth) - 3'h1;
  endproperty
  a_ret_pop: assert property (p_ret_pop)
    else $error("return did not pop stack");

  property p_ret_empty;
    core_en && pc_cmd.op == PC_INTERRUPT_RETURN && stack_empty |=>
      $stable(program_counter) && stack_empty;
  endproperty
  a_ret_empty: assert property (p_ret_empty)
    else $error("empty return moved state");

  property p_depth_cap;
    stack_depth <= 3'(STACK_LEVELS);
  endproperty
  a_depth_cap: assert property (p_depth_cap)
    else $error("stack depth above six");

  property p_ctx_onehot;
    $onehot(context_sel);
  endproperty
  a_ctx_onehot: assert property (p_ctx_onehot)
    else $error("context not one-hot");

  property p_nmi_round;
    core_en && pc_cmd.op == PC_NMI && context_sel == CTX_MAIN ##1
      (core_en && pc_cmd.op == PC_INTERRUPT_RETURN) |=> context_sel == CTX_MAIN;
  endproperty
  a_nmi_round: assert property (p_nmi_round)
    else $error("interrupt return lost prior context");

  property p_keep_main;
    context_sel != CTX_MAIN |=> $stable(main_carry) && $stable(main_zero);
  endproperty
  a_keep_main: assert property (p_keep_main)
    else $error("main pair changed outside its context");

  property p_zero_upd;
    core_en && flag_upd.zero_we && pc_cmd.op != PC_NMI &&
      pc_cmd.op != PC_IRQ && pc_cmd.op != PC_INTERRUPT_RETURN |=>
      active_zero == $past(flag_upd.zero);
  endproperty
  a_zero_upd: assert property (p_zero_upd)
    else $error("active zero flag not updated");

  property p_acc_map;
    core_en && ds_req.wr && ds_req.addr == ADDR_ACCUMULATOR && !acc_we |=>
      accumulator == $past(ds_req.wdata);
  endproperty
  a_acc_map: assert property (p_acc_map)
    else $error("accumulator write at FFh lost");

endmodule
`default_nettype wire

/* File: verification/cpfs_alu_model.sv */
// Purpose: Behavioural ALU standing on the far side of the register block
// Assumes: One operation per core cycle, qualified by go
// Notes: Results are combinational so they land on the same core edge
`timescale 1ns/1ps
`default_nettype none
module cpfs_alu_model
  import cpfs_pkg::*;
(
  // Operation request
  input wire logic go,
  input wire logic sub,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  // Results toward the register block
  output logic acc_we,
  output logic [7:0] acc_wdata,
  output cpfs_flag_upd_t flag_upd
);
  logic [8:0] res;
  always_comb
  begin
    res = sub ? ({1'b0, opa} - {1'b0, opb}) : ({1'b0, opa} + {1'b0, opb});
    acc_we = go;
    acc_wdata = res[7:0];
    flag_upd.carry_we = go;
    flag_upd.carry = res[8];
    flag_upd.zero_we = go;
    flag_upd.zero = ~|res[7:0];
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the core register block
// Assumes: CORE_DIV of 1, so every clock is a core cycle
// Notes: A reference model predicts the whole visible state each cycle
`timescale 1ns/1ps
`default_nettype none
module tb
  import cpfs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cpfs_ds_req_t ds_req = '0;
  cpfs_pc_cmd_t pc_cmd = '{op: PC_HOLD, target: 12'h000};
  cpfs_flag_upd_t flag_upd;
  logic go = 1'b0;
  logic sub = 1'b0;
  logic [7:0] opa = 8'h00;
  logic [7:0] opb = 8'h00;
  logic ind_sel = 1'b0;
  logic sd_start = 1'b0;
  logic [1:0] sd_sel = 2'h0;
  logic acc_we, ds_ack, sd_busy, active_carry, active_zero;
  logic [7:0] acc_wdata, ds_rdata, ind_addr, sd_addr, accumulator;
  logic [7:0] first_pointer, second_pointer;
  logic [7:0] first_short_direct, second_short_direct;
  logic [11:0] program_counter;
  logic [2:0] stack_depth;
  cpfs_ctx_t context_sel;
  logic [76:0] cur, ex;
  logic [76:0] st_q[$];
  int due_q[$];
  logic [7:0] rd_q[$];
  int cyc = 0;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h4d6e;
  logic [7:0] places[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84, 8'hfe};
  // Reference model state
  logic [11:0] m_prog, m_stk[6];
  logic [2:0] m_dep, m_sdc, m_c, m_z;
  cpfs_ctx_t m_ctx, m_sv;
  logic [7:0] m_r[5], m_sda, m_ind;

  assign cur = {program_counter, stack_depth, context_sel, active_carry,
    active_zero, ind_addr, sd_addr, sd_busy, accumulator, first_pointer,
    second_pointer, first_short_direct, second_short_direct};

  cpfs_core_regs #(.CORE_DIV(1)) dut (.clk(clk), .rst_n(rst_n),
    .ds_req(ds_req), .ds_rdata(ds_rdata), .ds_ack(ds_ack),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .flag_upd(flag_upd),
    .pc_cmd(pc_cmd), .program_counter(program_counter),
    .ind_sel(ind_sel), .ind_addr(ind_addr), .sd_start(sd_start),
    .sd_sel(sd_sel), .sd_addr(sd_addr), .sd_busy(sd_busy),
    .accumulator(accumulator), .first_pointer(first_pointer),
    .second_pointer(second_pointer),
    .first_short_direct(first_short_direct),
    .second_short_direct(second_short_direct),
    .active_carry(active_carry), .active_zero(active_zero),
    .context_sel(context_sel), .stack_depth(stack_depth));
  cpfs_alu_model alu (.go(go), .sub(sub), .opa(opa), .opb(opb),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .flag_upd(flag_upd));

  always #4 clk = ~clk;

  function automatic int ix(cpfs_ctx_t c);
    return c[1] ? 1 : (c[2] ? 2 : 0);
  endfunction

  // Register slot of a data-space byte, 5 when unmapped
  function automatic int slot(logic [7:0] ad);
    return (ad == 8'hff) ? 4 : ((ad[7:2] == 6'h20) ? int'(ad[1:0]) : 5);
  endfunction

  function automatic logic [76:0] exp_note();
    return {m_prog, m_dep, m_ctx, m_c[ix(m_ctx)], m_z[ix(m_ctx)], m_ind,
      m_sda, m_sdc != 3'h0, m_r[4], m_r[0], m_r[1], m_r[2], m_r[3]};
  endfunction

  task automatic chk_st(input logic [76:0] g, input logic [76:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One core cycle of stimulus; the model notes the state it must cause
  task automatic step(input cpfs_pc_op_t op = PC_HOLD,
      input logic [11:0] t = 12'h000, input logic g = 1'b0,
      input logic s = 1'b0, input logic [7:0] p1 = 8'h00,
      input logic [7:0] p2 = 8'h00, input cpfs_ds_req_t q = '0,
      input logic is = 1'b0, input logic st = 1'b0,
      input logic [1:0] sl = 2'h0);
    logic [8:0] r;
    int k;
    @(posedge clk);
    pc_cmd <= '{op: op, target: t};
    go <= g;
    sub <= s;
    opa <= p1;
    opb <= p2;
    ds_req <= q;
    ind_sel <= is;
    sd_start <= st;
    sd_sel <= sl;
    k = slot(q.addr);
    if (q.rd && k < 5)
      rd_q.push_back(m_r[k]);
    if (q.wr && k < 5)
      m_r[k] = q.wdata;
    r = s ? {1'b0, p1} - {1'b0, p2} : {1'b0, p1} + {1'b0, p2};
    if (g)
    begin
      m_r[4] = r[7:0];
      m_c[ix(m_ctx)] = r[8];
      m_z[ix(m_ctx)] = (r[7:0] == 8'h00);
    end
    if (st && m_sdc == 3'h0)
    begin
      m_sdc = SD_COUNT_LOAD;
      m_sda = ADDR_FIRST_POINTER + 8'(sl);
    end
    else if (m_sdc != 3'h0)
      m_sdc = m_sdc - 3'h1;
    m_ind = is ? m_r[1] : m_r[0];
    case (op)
      PC_SEQ: m_prog = m_prog + PC_STEP;
      PC_BRANCH, PC_JUMP: m_prog = t;
      PC_CALL, PC_IRQ, PC_NMI:
      begin
        for (int i = 5; i > 0; i--)
          m_stk[i] = m_stk[i-1];
        m_stk[0] = m_prog;
        m_prog = t;
        if (m_dep < 3'h6)
          m_dep = m_dep + 3'h1;
        if (op == PC_IRQ && m_ctx == CTX_MAIN)
          m_ctx = CTX_IRQ;
        if (op == PC_NMI)
        begin
          m_sv = m_ctx;
          m_ctx = CTX_URGENT;
        end
      end
      PC_RET, PC_INTERRUPT_RETURN:
      begin
        if (m_dep != 3'h0)
        begin
          m_prog = m_stk[0];
          for (int i = 0; i < 5; i++)
            m_stk[i] = m_stk[i+1];
          m_dep = m_dep - 3'h1;
        end
        // Interrupt return switches the pair even on an empty stack
        if (op == PC_INTERRUPT_RETURN)
        begin
          m_ctx = (m_ctx == CTX_URGENT) ? m_sv : CTX_MAIN;
          m_sv = CTX_MAIN;
        end
      end
      default: ;
    endcase
    st_q.push_back(exp_note());
    due_q.push_back(cyc + 2);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors++;
      stop_test();
    end
  end

  always @(negedge clk)
  begin
    if (due_q.size() != 0 && due_q[0] == cyc)
    begin
      due_q.delete(0);
      ex = st_q.pop_front();
      chk_st(cur[76:65], ex[76:65]);
      chk_st(cur[64:62], ex[64:62]);
      chk_st(cur[61:57], ex[61:57]);
      chk_st(cur[56:0], ex[56:0]);
    end
    if (ds_ack === 1'b1)
      chk_rd(ds_rdata, rd_q.size() != 0 ? rd_q.pop_front() : 8'hxx);
  end

  initial
  begin
    m_prog = PC_RESET;
    m_dep = 3'h0;
    m_ctx = CTX_URGENT;
    m_sv = CTX_MAIN;
    m_c = 3'h0;
    m_z = 3'h0;
    m_sdc = SD_COUNT_RESET;
    m_sda = REG_RESET;
    m_ind = REG_RESET;
    foreach (m_r[i])
      m_r[i] = REG_RESET;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_st(cur, exp_note());
    // Writes with random data, unmapped places among them, then reads
    foreach (places[i])
      step(PC_HOLD, 0, 0, 0, 0, 0, '{1'b0, 1'b1, places[i],
        8'($random(seed))}, i[0]);
    foreach (places[i])
      step(PC_HOLD, 0, 0, 0, 0, 0, '{1'b1, 1'b0, places[i], 8'h00}, i[0]);
    // Accumulator write from the ALU wins over a data write to FFh
    step(PC_HOLD, 0, 1, 0, 8'h0f, 8'h01, '{1'b0, 1'b1, 8'hff, 8'h55});
    step(PC_HOLD, 0, 0, 0, 0, 0, '{1'b1, 1'b0, 8'hff, 8'h00});
    // Short-direct slots, a second start while busy is ignored
    for (int i = 0; i < 4; i++)
    begin
      step(PC_HOLD, 0, 0, 0, 0, 0, '0, 0, 1, 2'(i));
      step(PC_HOLD, 0, 0, 0, 0, 0, '0, 0, 1, 2'(~i));
      repeat (3) step();
    end
    step(PC_JUMP, 12'h100);
    step(PC_SEQ);
    step(PC_BRANCH, 12'h0f8);
    step(PC_JUMP, 12'hfff);
    step(PC_SEQ);
    // Seven nested calls overflow the stack, seven returns underflow it
    for (int i = 0; i < 7; i++)
      step(PC_CALL, 12'h200 + 12'(i));
    repeat (7) step(PC_RET);
    // Flag pairs across interrupt entry and return
    step(PC_IRQ, 12'h3f0, 1, 0, 8'hff, 8'h01);
    step(PC_INTERRUPT_RETURN);
    step(PC_HOLD, 0, 1, 1, 8'h10, 8'h20);
    step(PC_IRQ, 12'h3f0);
    step(PC_HOLD, 0, 1, 0, 8'h80, 8'h80);
    step(PC_NMI, 12'h3fc, 1, 1, 8'h01, 8'h02);
    step(PC_HOLD, 0, 1, 1, 8'h33, 8'h33);
    step(PC_INTERRUPT_RETURN);
    step(PC_INTERRUPT_RETURN);
    // Urgent entry from main and back, then returns on an empty stack
    step(PC_NMI, 12'h3fc);
    step(PC_INTERRUPT_RETURN);
    step(PC_INTERRUPT_RETURN, 0, 1, 1, 8'h01, 8'h01);
    step(PC_NMI, 12'h3fc);
    step(PC_RET);
    step(PC_INTERRUPT_RETURN);
    repeat (8)
      step(PC_SEQ, 0, 1, 1'($random(seed)), 8'($random(seed)),
        8'($random(seed)));
    repeat (2) step();
    repeat (3) @(negedge clk);
    chk_rd(8'(rd_q.size()), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
